// [transceiver_interrupt_mask_logic.sv]
// Purpose: Interrupt pending flags and enable masks with one interrupt request
// Assumes: Event inputs synchronous to mclk; register strobes one cycle long
// Notes:   Read data and the request come from flip-flops
// Overview of operation
// - Main node flags interrupt frame checksum error
// - Bit 1 flags failed I2C transaction
// - Bit 0 flags discovery; zero on subordinate
// - Mask at 0x1B gates error pending flags
// - Error enable bit order from 7 to 0
// - Mask at 0x1C gates pin n pending
// - Mask at 0x1D gates main event pending
// - Main mask bits 3..0 event assignment
// - Main event gating only on main node
// - Subordinate interrupt flag; zero on subordinate
// - Pin n pending; pin 0 zero on main
`timescale 1ns/10ps
`include "trans_irq_map.svh"
module transceiver_interrupt_mask_logic (
  input wire logic mclk,
  input wire logic rst,
  input wire trans_irq_pkg::reg_addr_t regAddr,
  input wire trans_irq_pkg::reg_byte_t regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  output trans_irq_pkg::reg_byte_t regReadData,
  input wire logic mainNode,
  input wire trans_irq_pkg::reg_byte_t errorEvents,
  input wire trans_irq_pkg::reg_byte_t pinEvents,
  input wire logic subordinateIrqEvent,
  input wire logic frameChecksumEvent,
  input wire logic i2cErrorEvent,
  input wire logic discoveryEvent,
  output logic interruptRequest
);
  import trans_irq_pkg::*;

  reg_byte_t errorInterruptEnables;
  reg_byte_t pinInterruptEnables;
  reg_byte_t mainEventEnables;

  pending_bus_if errorBus ();
  pending_bus_if pinBus ();
  pending_bus_if mainBus ();

  function automatic reg_sel_t decodeAddr(input reg_addr_t a);
    reg_sel_t s;
    s = SEL_NONE;
    unique case (a)
      `OFS_ERROR_PENDING: s = SEL_ERROR_PENDING;
      `OFS_PIN_PENDING: s = SEL_PIN_PENDING;
      `OFS_MAIN_EVENT_PENDING: s = SEL_MAIN_PENDING;
      `OFS_ERROR_ENABLES: s = SEL_ERROR_ENABLES;
      `OFS_PIN_ENABLES: s = SEL_PIN_ENABLES;
      `OFS_MAIN_EVENT_ENABLES: s = SEL_MAIN_ENABLES;
      default: s = SEL_NONE;
    endcase
    return s;
  endfunction : decodeAddr

  // One enabled pending bit anywhere in a bank raises the request
  function automatic logic anyEnabled(input reg_byte_t flags, input reg_byte_t enables);
    return |(flags & enables);
  endfunction : anyEnabled

  wire reg_sel_t sel = decodeAddr(regAddr);
  wire logic wrErrorPend = regWrite && (sel == SEL_ERROR_PENDING);
  wire logic wrPinPend = regWrite && (sel == SEL_PIN_PENDING);
  wire logic wrMainPend = regWrite && (sel == SEL_MAIN_PENDING);
  wire logic wrErrorEn = regWrite && (sel == SEL_ERROR_ENABLES);
  wire logic wrPinEn = regWrite && (sel == SEL_PIN_ENABLES);
  wire logic wrMainEn = regWrite && (sel == SEL_MAIN_ENABLES);

  // Main event bank: 3 subordinate irq, 2 frame checksum, 1 I2C, 0 discovery
  wire reg_byte_t mainEvents = {
    4'h0,
    subordinateIrqEvent,
    frameChecksumEvent,
    i2cErrorEvent,
    discoveryEvent
  };

  // Error event inputs, named in enable order
  wire logic subrespChecksumEvent = errorEvents[`BIT_SUBRESP_CHECKSUM_ERR];
  wire logic subrespFrameEvent = errorEvents[`BIT_SUBRESP_FRAME_ERR];
  wire logic bitErrorCountEvent = errorEvents[`BIT_BIT_ERROR_COUNT];
  wire logic switchReportingEvent = errorEvents[`BIT_SWITCH_REPORTING_ERR];
  wire logic dataParityEvent = errorEvents[`BIT_DATA_PARITY_ERR];
  wire logic checksumEvent = errorEvents[`BIT_CHECKSUM_ERR];
  wire logic dataDecodingEvent = errorEvents[`BIT_DATA_DECODING_ERR];
  wire logic headerCountEvent = errorEvents[`BIT_HEADER_COUNT_ERR];
  wire reg_byte_t errorEventView = {
    subrespChecksumEvent,
    subrespFrameEvent,
    bitErrorCountEvent,
    switchReportingEvent,
    dataParityEvent,
    checksumEvent,
    dataDecodingEvent,
    headerCountEvent
  };

  // Error pending bank; bit order matches the error enables
  assign errorBus.setBits = errorEventView;
  assign errorBus.clearBits = regWriteData;
  assign errorBus.clearWrite = wrErrorPend;
  assign errorBus.keepMask = 8'hff;

  // Pin pending bank
  assign pinBus.setBits = pinEvents;
  assign pinBus.clearBits = regWriteData;
  assign pinBus.clearWrite = wrPinPend;
  // Pin 0 carries the bus interrupt line on a main node, so it never flags there
  assign pinBus.keepMask = mainNode ? `PIN0_MASK_ON_MAIN : 8'hff;

  // Main event pending bank
  assign mainBus.setBits = mainEvents;
  assign mainBus.clearBits = regWriteData;
  assign mainBus.clearWrite = wrMainPend;
  // A subordinate holds these flags at zero
  assign mainBus.keepMask = mainNode ? `MAIN_EVENT_USED : 8'h00;

  pending_flags errorBank (
    .mclk(mclk),
    .rst(rst),
    .pb(errorBus.bank)
  );

  pending_flags pinBank (
    .mclk(mclk),
    .rst(rst),
    .pb(pinBus.bank)
  );

  pending_flags mainBank (
    .mclk(mclk),
    .rst(rst),
    .pb(mainBus.bank)
  );

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      errorInterruptEnables <= `RST_ENABLES;
    end else if (wrErrorEn) begin
      errorInterruptEnables <= regWriteData;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pinInterruptEnables <= `RST_ENABLES;
    end else if (wrPinEn) begin
      pinInterruptEnables <= regWriteData;
    end
  end

  // Upper four bits have no event behind them and read back as zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mainEventEnables <= `RST_ENABLES;
    end else if (wrMainEn) begin
      mainEventEnables <= regWriteData & `MAIN_EVENT_USED;
    end
  end

  // Error enable fields, bit 7 down to bit 0
  wire logic subrespChecksumErrorEnable = errorInterruptEnables[`BIT_SUBRESP_CHECKSUM_ERR];
  wire logic subrespFrameErrorEnable = errorInterruptEnables[`BIT_SUBRESP_FRAME_ERR];
  wire logic bitErrorCountEnable = errorInterruptEnables[`BIT_BIT_ERROR_COUNT];
  wire logic switchReportingErrorEnable = errorInterruptEnables[`BIT_SWITCH_REPORTING_ERR];
  wire logic dataParityErrorEnable = errorInterruptEnables[`BIT_DATA_PARITY_ERR];
  wire logic checksumErrorEnable = errorInterruptEnables[`BIT_CHECKSUM_ERR];
  wire logic dataDecodingErrorEnable = errorInterruptEnables[`BIT_DATA_DECODING_ERR];
  wire logic headerCountErrorEnable = errorInterruptEnables[`BIT_HEADER_COUNT_ERR];
  wire reg_byte_t errorEnableView = {
    subrespChecksumErrorEnable,
    subrespFrameErrorEnable,
    bitErrorCountEnable,
    switchReportingErrorEnable,
    dataParityErrorEnable,
    checksumErrorEnable,
    dataDecodingErrorEnable,
    headerCountErrorEnable
  };

  // Error pending fields in the same order
  wire logic subrespChecksumError = errorBus.value[`BIT_SUBRESP_CHECKSUM_ERR];
  wire logic subrespFrameError = errorBus.value[`BIT_SUBRESP_FRAME_ERR];
  wire logic bitErrorCountReached = errorBus.value[`BIT_BIT_ERROR_COUNT];
  wire logic switchReportingError = errorBus.value[`BIT_SWITCH_REPORTING_ERR];
  wire logic dataParityError = errorBus.value[`BIT_DATA_PARITY_ERR];
  wire logic checksumError = errorBus.value[`BIT_CHECKSUM_ERR];
  wire logic dataDecodingError = errorBus.value[`BIT_DATA_DECODING_ERR];
  wire logic headerCountError = errorBus.value[`BIT_HEADER_COUNT_ERR];

  // Each error flag passes only beside its own enable
  wire reg_byte_t errorGated = {
    subrespChecksumError & subrespChecksumErrorEnable,
    subrespFrameError & subrespFrameErrorEnable,
    bitErrorCountReached & bitErrorCountEnable,
    switchReportingError & switchReportingErrorEnable,
    dataParityError & dataParityErrorEnable,
    checksumError & checksumErrorEnable,
    dataDecodingError & dataDecodingErrorEnable,
    headerCountError & headerCountErrorEnable
  };
  wire logic errorHit = |errorGated;

  // Pin enable fields, bit n for pin n
  wire logic pin7InterruptEnable = pinInterruptEnables[7];
  wire logic pin6InterruptEnable = pinInterruptEnables[6];
  wire logic pin5InterruptEnable = pinInterruptEnables[5];
  wire logic pin4InterruptEnable = pinInterruptEnables[4];
  wire logic pin3InterruptEnable = pinInterruptEnables[3];
  wire logic pin2InterruptEnable = pinInterruptEnables[2];
  wire logic pin1InterruptEnable = pinInterruptEnables[1];
  wire logic pin0InterruptEnable = pinInterruptEnables[0];
  wire reg_byte_t pinEnableView = {
    pin7InterruptEnable,
    pin6InterruptEnable,
    pin5InterruptEnable,
    pin4InterruptEnable,
    pin3InterruptEnable,
    pin2InterruptEnable,
    pin1InterruptEnable,
    pin0InterruptEnable
  };

  // Pin pending fields; pin 0 is held clear on a main node
  wire logic pin7Pending = pinBus.value[7];
  wire logic pin6Pending = pinBus.value[6];
  wire logic pin5Pending = pinBus.value[5];
  wire logic pin4Pending = pinBus.value[4];
  wire logic pin3Pending = pinBus.value[3];
  wire logic pin2Pending = pinBus.value[2];
  wire logic pin1Pending = pinBus.value[1];
  wire logic pin0Pending = pinBus.value[0];
  wire reg_byte_t pinPendingView = {
    pin7Pending,
    pin6Pending,
    pin5Pending,
    pin4Pending,
    pin3Pending,
    pin2Pending,
    pin1Pending,
    pin0Pending
  };
  wire logic pinHit = anyEnabled(pinPendingView, pinEnableView);

  // Main event enable fields
  wire logic subordinateInterruptEnable = mainEventEnables[`BIT_SUBORDINATE_IRQ];
  wire logic interruptFrameChecksumEnable = mainEventEnables[`BIT_IFRAME_CHECKSUM_ERR];
  wire logic i2cErrorEnable = mainEventEnables[`BIT_I2C_TRANSACTION_ERR];
  wire logic discoveryCompleteEnable = mainEventEnables[`BIT_DISCOVERY_COMPLETE];
  wire reg_byte_t mainEnableView = {
    4'h0,
    subordinateInterruptEnable,
    interruptFrameChecksumEnable,
    i2cErrorEnable,
    discoveryCompleteEnable
  };

  // Main event pending fields
  wire logic subordinateInterruptSeen = mainBus.value[`BIT_SUBORDINATE_IRQ];
  wire logic interruptFrameChecksumError = mainBus.value[`BIT_IFRAME_CHECKSUM_ERR];
  wire logic i2cTransactionError = mainBus.value[`BIT_I2C_TRANSACTION_ERR];
  wire logic discoveryComplete = mainBus.value[`BIT_DISCOVERY_COMPLETE];
  wire reg_byte_t mainPendingView = {
    4'h0,
    subordinateInterruptSeen,
    interruptFrameChecksumError,
    i2cTransactionError,
    discoveryComplete
  };

  // Main events reach the request only on a main node
  wire logic mainHit = mainNode && anyEnabled(mainPendingView, mainEnableView);
  wire logic next_interruptRequest = errorHit | pinHit | mainHit;

  reg_byte_t next_readData;
  always_comb begin
    next_readData = '0;
    unique case (sel)
      SEL_ERROR_PENDING: next_readData = errorBus.value;
      SEL_PIN_PENDING: next_readData = pinPendingView;
      SEL_MAIN_PENDING: next_readData = mainPendingView;
      SEL_ERROR_ENABLES: next_readData = errorEnableView;
      SEL_PIN_ENABLES: next_readData = pinEnableView;
      SEL_MAIN_ENABLES: next_readData = mainEnableView;
      SEL_NONE: next_readData = '0;
    endcase
  end

  // Read data stand only in the cycle after the read strobe
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      regReadData <= '0;
    end else begin
      regReadData <= regRead ? next_readData : '0;
    end
  end

  // Registered so the request is glitch free; one cycle behind the flags
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      interruptRequest <= 1'b0;
    end else begin
      interruptRequest <= next_interruptRequest;
    end
  end
endmodule : transceiver_interrupt_mask_logic

// [trans_irq_map.svh]
// Purpose: Register offsets, field positions and reset values of the interrupt mask block
// Assumes: Byte-wide registers on a plain synchronous register port
// Notes:   Offsets are byte addresses on the register port
`ifndef TRANS_IRQ_MAP_SVH
`define TRANS_IRQ_MAP_SVH

`define ADDR_W 8
`define DATA_W 8

`define OFS_ERROR_PENDING 8'h18
`define OFS_PIN_PENDING 8'h19
`define OFS_MAIN_EVENT_PENDING 8'h1a
`define OFS_ERROR_ENABLES 8'h1b
`define OFS_PIN_ENABLES 8'h1c
`define OFS_MAIN_EVENT_ENABLES 8'h1d

`define RST_ENABLES 8'h00
`define RST_PENDING 8'h00

// Error enables, bit 7 down to bit 0
`define BIT_SUBRESP_CHECKSUM_ERR 7
`define BIT_SUBRESP_FRAME_ERR 6
`define BIT_BIT_ERROR_COUNT 5
`define BIT_SWITCH_REPORTING_ERR 4
`define BIT_DATA_PARITY_ERR 3
`define BIT_CHECKSUM_ERR 2
`define BIT_DATA_DECODING_ERR 1
`define BIT_HEADER_COUNT_ERR 0

// Main-node event bits
`define BIT_SUBORDINATE_IRQ 3
`define BIT_IFRAME_CHECKSUM_ERR 2
`define BIT_I2C_TRANSACTION_ERR 1
`define BIT_DISCOVERY_COMPLETE 0
`define MAIN_EVENT_USED 8'h0f

// Pin 0 of the pin pending register reads zero on a main node
`define PIN0_MASK_ON_MAIN 8'hfe

`endif

// [trans_irq_pkg.sv]
// Purpose: Types shared by the interrupt mask block
// Assumes: Constants come from trans_irq_map.svh
// Notes:   Holds types only
package trans_irq_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef logic [7:0] reg_addr_t;
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_ERROR_PENDING,
    SEL_PIN_PENDING,
    SEL_MAIN_PENDING,
    SEL_ERROR_ENABLES,
    SEL_PIN_ENABLES,
    SEL_MAIN_ENABLES
  } reg_sel_t;
endpackage : trans_irq_pkg

// [pending_bus_if.sv]
// Purpose: Connection between the register decoder and one pending flag bank
// Assumes: One clock domain
// Notes:   value is the flag bank state after the keep mask
`timescale 1ns/10ps
interface pending_bus_if;
  import trans_irq_pkg::*;
  reg_byte_t setBits;
  reg_byte_t clearBits;
  logic clearWrite;
  reg_byte_t keepMask;
  reg_byte_t value;
  modport ctrl (output setBits, output clearBits, output clearWrite, output keepMask,
    input value);
  modport bank (input setBits, input clearBits, input clearWrite, input keepMask,
    output value);
endinterface : pending_bus_if

// [pending_flags.sv]
// Purpose: Bank of sticky pending flags, write one to clear
// Assumes: Event inputs are synchronous one-cycle or level pulses
// Notes:   A set in the same cycle as a clear keeps the flag set
`timescale 1ns/10ps
module pending_flags (
  input wire logic mclk,
  input wire logic rst,
  pending_bus_if.bank pb
);
  import trans_irq_pkg::*;

  reg_byte_t flags;
  reg_byte_t next_flags;
  wire reg_byte_t clearNow = pb.clearWrite ? pb.clearBits : '0;

  // Set wins over clear so an event landing on the clear write is not lost
  assign next_flags = ((flags & ~clearNow) | pb.setBits) & pb.keepMask;
  assign pb.value = flags;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flags <= `RST_PENDING;
    end else begin
      flags <= next_flags;
    end
  end
endmodule : pending_flags

// [trans_irq_assertions.sv]
// Purpose: Port-level checks of the interrupt mask block
// Assumes: Strobes one cycle long, never both
// Notes:   Enables are shadowed from register writes
`timescale 1ns/10ps
module trans_irq_assertions (
  input wire logic mclk,
  input wire logic rst,
  input wire trans_irq_pkg::reg_addr_t regAddr,
  input wire trans_irq_pkg::reg_byte_t regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire trans_irq_pkg::reg_byte_t regReadData,
  input wire logic mainNode,
  input wire trans_irq_pkg::reg_byte_t errorEvents,
  input wire trans_irq_pkg::reg_byte_t pinEvents,
  input wire logic subordinateIrqEvent,
  input wire logic frameChecksumEvent,
  input wire logic i2cErrorEvent,
  input wire logic discoveryEvent,
  input wire logic interruptRequest
);
  import trans_irq_pkg::*;
  reg_byte_t en0, en1, en2;
  wire logic [3:0] mainEv = {subordinateIrqEvent, frameChecksumEvent,
    i2cErrorEvent, discoveryEvent};
  wire logic anyEv = |{errorEvents, pinEvents, mainEv};
  wire reg_byte_t enSel = (regAddr == 8'h1b) ? en0 : (regAddr == 8'h1c) ? en1 : en2;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      {en0, en1, en2} <= 24'h0;
    end else if (regWrite) begin
      if (regAddr == 8'h1b) en0 <= regWriteData;
      if (regAddr == 8'h1c) en1 <= regWriteData;
      if (regAddr == 8'h1d) en2 <= regWriteData & 8'h0f;
    end
  end
  a_mask_read_back: assert property (regRead && regAddr inside {8'h1b, 8'h1c, 8'h1d}
    |=> regReadData == $past(enSel)) else $error("enable read-back wrong");
  a_sub_main_zero: assert property (regRead && regAddr == 8'h1a && !mainNode
    && !$past(mainNode) |=> regReadData == 8'h00) else $error("main flags on subordinate");
  a_pin0_main_zero: assert property (regRead && regAddr == 8'h19 && mainNode
    && $past(mainNode) |=> !regReadData[0]) else $error("pin 0 flag on main");
  a_error_irq: assert property (|(errorEvents & en0) && !regWrite
    |-> ##2 interruptRequest) else $error("no request for error event");
  a_pin_irq: assert property (|(pinEvents[7:1] & en1[7:1]) && !regWrite
    |-> ##2 interruptRequest) else $error("no request for pin event");
  a_main_irq: assert property (mainNode && |(mainEv & en2[3:0]) && !regWrite
    ##1 mainNode |-> ##1 interruptRequest) else $error("no request for main event");
  a_irq_quiet: assert property (((en0 | en1 | en2) == 8'h00) [*2]
    |-> !interruptRequest) else $error("request with enables clear");
  a_rise_has_cause: assert property ($rose(interruptRequest)
    |-> $past(anyEv || regWrite, 2)) else $error("request rose without cause");
endmodule : trans_irq_assertions

// [testbench.sv]
// Purpose: Self-checking bench of the interrupt mask block
// Assumes: Read data stands in the cycle after the strobe
// Notes:   Reads queue their expectation; a monitor pops one per answer
`timescale 1ns/10ps
module testbench;
  import trans_irq_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, regWrite = 1'b0, regRead = 1'b0, mainNode = 1'b1;
  logic answerDue = 1'b0, interruptRequest;
  logic [3:0] mainEv = 4'h0;
  reg_addr_t regAddr = 8'h00;
  reg_byte_t regWriteData = 8'h00, errorEvents = 8'h00, pinEvents = 8'h00;
  reg_byte_t regReadData, m0, m1, m2, e0, p0;
  reg_byte_t expQ[$];
  logic irqQ[$];
  logic irqDue = 1'b0;
  logic [31:0] seed = 32'h2ef4eb21;
  int failCount = 0, numChecks = 0;
  transceiver_interrupt_mask_logic transceiver_interrupt_mask_logic_inst (
    .mclk(mclk), .rst(rst), .regAddr(regAddr), .regWriteData(regWriteData),
    .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData),
    .mainNode(mainNode), .errorEvents(errorEvents), .pinEvents(pinEvents),
    .subordinateIrqEvent(mainEv[3]), .frameChecksumEvent(mainEv[2]),
    .i2cErrorEvent(mainEv[1]), .discoveryEvent(mainEv[0]),
    .interruptRequest(interruptRequest));
  initial forever #2 mclk = ~mclk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic check(input string what, input reg_byte_t exp, input reg_byte_t got);
    numChecks++;
    if (got !== exp) begin
      failCount++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic check_request(input logic exp, input logic got);
    numChecks++;
    if (got !== exp) begin
      failCount++;
      $display("BAD interrupt request expected %b seen %b", exp, got);
    end
  endtask : check_request
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", numChecks, failCount);
    if (failCount == 0 && numChecks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop
  // One strobe cycle; a read also queues its expected answer
  task automatic bus(input logic w, input reg_addr_t a, input reg_byte_t d);
    @(posedge mclk);
    {regWrite, regRead, regAddr, regWriteData} <= {w, !w, a, d};
    if (!w) expQ.push_back(d);
    @(posedge mclk);
    {regWrite, regRead} <= 2'b00;
  endtask : bus
  // Ends where the request for the pulsed events has settled
  task automatic fire(input reg_byte_t e, input reg_byte_t p, input logic [3:0] m);
    @(posedge mclk);
    {errorEvents, pinEvents, mainEv} <= {e, p, m};
    @(posedge mclk);
    {errorEvents, pinEvents, mainEv} <= 20'h0;
    repeat (2) @(negedge mclk);
  endtask : fire
  // Queues the expected request level; the monitor compares it mid-cycle
  task automatic expect_request(input logic exp);
    @(posedge mclk);
    irqQ.push_back(exp);
    irqDue <= 1'b1;
    @(posedge mclk);
    irqDue <= 1'b0;
  endtask : expect_request
  always @(posedge mclk) answerDue <= regRead;
  always @(negedge mclk) if (answerDue) check("read data", expQ.pop_front(), regReadData);
  always @(negedge mclk) if (irqDue) check_request(irqQ.pop_front(), interruptRequest);
  initial begin
    #40000;
    failCount++;
    report_and_stop();
  end
  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    for (int a = 24; a < 31; a++) bus(1'b0, 8'(a), 8'h00);
    seed = xs(seed);
    {m0, m1, m2, e0} = seed;
    seed = xs(seed);
    p0 = seed[7:0];
    bus(1'b1, 8'h1b, m0);
    bus(1'b1, 8'h1c, m1);
    bus(1'b1, 8'h1d, m2);
    bus(1'b0, 8'h1b, m0);
    bus(1'b0, 8'h1c, m1);
    bus(1'b0, 8'h1d, m2 & 8'h0f);
    fire(e0, p0, 4'hf);
    expect_request(|{e0 & m0, p0 & m1 & 8'hfe, m2[3:0]});
    bus(1'b0, 8'h18, e0);
    bus(1'b0, 8'h19, p0 & 8'hfe);
    bus(1'b0, 8'h1a, 8'h0f);
    bus(1'b1, 8'h1a, 8'h02);
    bus(1'b0, 8'h1a, 8'h0d);
    for (int a = 24; a < 27; a++) bus(1'b1, 8'(a), 8'hff);
    bus(1'b0, 8'h18, 8'h00);
    expect_request(1'b0);
    // An event on the clearing edge must survive the clear
    mainEv <= 4'h2;
    bus(1'b1, 8'h1a, 8'h02);
    mainEv <= 4'h0;
    bus(1'b0, 8'h1a, 8'h02);
    mainNode <= 1'b0;
    fire(8'h00, 8'h01, 4'hf);
    expect_request(m1[0]);
    bus(1'b0, 8'h1a, 8'h00);
    bus(1'b0, 8'h19, 8'h01);
    repeat (2) @(posedge mclk);
    report_and_stop();
  end
endmodule : testbench
bind transceiver_interrupt_mask_logic trans_irq_assertions trans_irq_assertions_inst (
  .mclk(mclk), .rst(rst), .regAddr(regAddr), .regWriteData(regWriteData),
  .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData),
  .mainNode(mainNode), .errorEvents(errorEvents), .pinEvents(pinEvents),
  .subordinateIrqEvent(subordinateIrqEvent), .frameChecksumEvent(frameChecksumEvent),
  .i2cErrorEvent(i2cErrorEvent), .discoveryEvent(discoveryEvent),
  .interruptRequest(interruptRequest));
